// [lsm_pkg.sv]
package lsm_pkg;
  localparam int unsigned NREG    = 32;
  localparam int unsigned SP_IDX  = 14;
  localparam int unsigned LR_IDX  = 15;
  localparam int unsigned PTR_OFS = 16;
  localparam logic [31:0] PC_RST  = 32'h0000_0000;
  localparam logic [10:0] EXT_RST = 11'h000;
  // Full-word opcode patterns, compared against masked instruction
  localparam logic [15:0] M_TOP4  = 16'hf000;
  localparam logic [15:0] M_TOP6  = 16'hfc00;
  localparam logic [15:0] M_TOP11 = 16'hffe0;
  localparam logic [15:0] M_ALL   = 16'hffff;
  localparam logic [15:0] OP_PTR  = 16'hb000;
  localparam logic [15:0] M_TOP3  = 16'he000;
  localparam logic [15:0] OP_STK  = 16'he000;
  localparam logic [15:0] OP_LINK_RETURN = 16'h7fcf;
  localparam logic [15:0] OP_SLI  = 16'h1c00;
  localparam logic [15:0] OP_SRR  = 16'h2000;
  localparam logic [15:0] OP_SRI  = 16'h2400;
  localparam logic [15:0] OP_COPY = 16'h3000;
  localparam logic [15:0] OP_UHI  = 16'h6c00;
  localparam logic [15:0] OP_IMM  = 16'h3400;
  localparam logic [15:0] OP_MST  = 16'h7e80;
  localparam logic [15:0] OP_MUL  = 16'h7ce0;
  localparam logic [15:0] OP_NEG  = 16'h7c20;
  localparam logic [15:0] M_PFX   = 16'hf800;
  localparam logic [15:0] OP_PFX  = 16'h9800;
  typedef enum logic [3:0] {
    LSM_NONE, LSM_PTR, LSM_STK, LSM_LINK_RETURN, LSM_SLI, LSM_SRR, LSM_SRI, LSM_COPY,
    LSM_UHI, LSM_IMM, LSM_MST, LSM_MUL, LSM_NEG, LSM_PFX
  } lsm_op_t;
  typedef enum logic [1:0] {LSM_IDLE, LSM_LOAD, LSM_SLOT} lsm_state_t;
endpackage

// [lsm_core.sv]
`timescale 1ns/1ps
`default_nettype none
module lsm_core (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ins_valid,
  input  wire logic [15:0] i_ins,
  input  wire logic [3:0]  i_flags,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  output logic             o_ins_ready,
  output logic             o_mem_req,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_pc,
  output logic             o_jump,
  output logic [31:0]      o_jump_target,
  output logic             o_busy,
  output logic [3:0]       o_flags,
  output logic [10:0]      o_ext,
  output logic [31:0]      o_reg_zero
);
  function automatic lsm_pkg::lsm_op_t decode(input logic [15:0] w);
    decode = lsm_pkg::LSM_NONE;
    if ((w & lsm_pkg::M_TOP4) == lsm_pkg::OP_PTR) decode = lsm_pkg::LSM_PTR;
    else if ((w & lsm_pkg::M_TOP3) == lsm_pkg::OP_STK) decode = lsm_pkg::LSM_STK;
    else if (w == lsm_pkg::OP_LINK_RETURN) decode = lsm_pkg::LSM_LINK_RETURN;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_SLI) decode = lsm_pkg::LSM_SLI;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_SRR) decode = lsm_pkg::LSM_SRR;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_SRI) decode = lsm_pkg::LSM_SRI;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_COPY) decode = lsm_pkg::LSM_COPY;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_UHI) decode = lsm_pkg::LSM_UHI;
    else if ((w & lsm_pkg::M_TOP6) == lsm_pkg::OP_IMM) decode = lsm_pkg::LSM_IMM;
    else if ((w & lsm_pkg::M_TOP11) == lsm_pkg::OP_MST) decode = lsm_pkg::LSM_MST;
    else if ((w & lsm_pkg::M_TOP11) == lsm_pkg::OP_MUL) decode = lsm_pkg::LSM_MUL;
    else if ((w & lsm_pkg::M_TOP11) == lsm_pkg::OP_NEG) decode = lsm_pkg::LSM_NEG;
    else if ((w & lsm_pkg::M_PFX) == lsm_pkg::OP_PFX) decode = lsm_pkg::LSM_PFX;
  endfunction

  logic [31:0]         regs_q [lsm_pkg::NREG];
  logic [10:0]         ext_q;
  logic [31:0]         pc_q;
  logic [3:0]          flags_q;
  logic                jump_q;
  logic [31:0]         target_q;
  logic                mem_req_q;
  logic [31:0]         mem_addr_q;
  logic [4:0]          ld_dst_q;
  logic                ready_q;
  lsm_pkg::lsm_state_t state_q;
  lsm_pkg::lsm_op_t    op;
  logic [4:0]          ra;
  logic [4:0]          rb;
  logic [4:0]          five_bit_immediate;
  logic [7:0]          eight_bit_immediate;
  logic [1:0]          pidx;
  logic [31:0]         va;
  logic [31:0]         vb;
  logic [31:0]         r0;
  logic [15:0]         kimm;
  logic                take;
  logic                wr_en;
  logic [4:0]          wr_idx;
  logic [31:0]         wr_val;
  logic                slot_ok;
  logic [31:0]         ptr_off;
  logic [31:0]         stk_off;

  assign op   = decode(i_ins);
  assign ra   = i_ins[4:0];
  assign rb   = i_ins[9:5];
  assign five_bit_immediate = i_ins[9:5];
  assign eight_bit_immediate = i_ins[12:5];
  assign pidx = i_ins[11:10];
  assign va   = regs_q[ra];
  assign vb   = regs_q[rb];
  assign r0   = regs_q[0];
  assign kimm = {ext_q, five_bit_immediate};
  assign take = i_ins_valid && ready_q;
  // Prefixed pointer offset is signed, unlike the zero-extended moves
  assign ptr_off = {{14{ext_q[10]}}, ext_q, five_bit_immediate, 2'b00};
  assign stk_off = {22'h000000, eight_bit_immediate, 2'b00};
  // Jump or load in the delay slot is not a permitted kind; it is dropped
  assign slot_ok = (op != lsm_pkg::LSM_LINK_RETURN) && (op != lsm_pkg::LSM_PTR) && (op != lsm_pkg::LSM_STK);

  always_comb begin
    wr_en  = 1'b0;
    wr_idx = ra;
    wr_val = va;
    // Load data lands at the ack edge; no other write happens in that cycle
    if (state_q == lsm_pkg::LSM_LOAD) begin
      wr_en  = i_mem_ack;
      wr_idx = ld_dst_q;
      wr_val = i_mem_rdata;
    end else if (take && (state_q == lsm_pkg::LSM_IDLE || slot_ok)) begin
      wr_en = 1'b1;
      unique case (op)
        lsm_pkg::LSM_SLI:  wr_val = va << five_bit_immediate;
        lsm_pkg::LSM_SRR:  wr_val = va >> vb[4:0];
        lsm_pkg::LSM_SRI:  wr_val = va >> five_bit_immediate;
        lsm_pkg::LSM_COPY: wr_val = vb;
        lsm_pkg::LSM_UHI:  wr_val = {kimm, va[15:0]};
        lsm_pkg::LSM_IMM:  wr_val = {16'h0000, kimm};
        lsm_pkg::LSM_NEG:  wr_val = 32'h0000_0000 - va;
        lsm_pkg::LSM_MST: begin
          wr_idx = 5'h00;
          wr_val = r0[31] ? ((r0 << 1) + va) : (r0 << 1);
        end
        lsm_pkg::LSM_MUL: begin
          wr_idx = 5'h00;
          wr_val = r0[15:0] * va[15:0];
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < lsm_pkg::NREG; i++) begin
        regs_q[i] <= 32'h0000_0000;
      end
    end else if (wr_en) begin
      regs_q[wr_idx] <= wr_val;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_q <= lsm_pkg::EXT_RST;
    end else if (take) begin
      ext_q <= (op == lsm_pkg::LSM_PFX) ? i_ins[10:0] : lsm_pkg::EXT_RST;
    end
  end

  // Flags pass through untouched by every instruction handled here
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= i_flags;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= lsm_pkg::LSM_IDLE;
      mem_req_q  <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      ld_dst_q   <= 5'h00;
      jump_q     <= 1'b0;
      target_q   <= 32'h0000_0000;
      pc_q       <= lsm_pkg::PC_RST;
      ready_q    <= 1'b0;
    end else begin
      jump_q  <= 1'b0;
      ready_q <= 1'b1;
      unique case (state_q)
        lsm_pkg::LSM_IDLE: begin
          if (take) begin
            pc_q <= pc_q + 32'd2;
            unique case (op)
              lsm_pkg::LSM_PTR: begin
                state_q    <= lsm_pkg::LSM_LOAD;
                mem_req_q  <= 1'b1;
                ready_q    <= 1'b0;
                ld_dst_q   <= ra;
                mem_addr_q <= {regs_q[5'(lsm_pkg::PTR_OFS) + {3'h0, pidx}][31:2], 2'b00}
                              + ptr_off;
              end
              lsm_pkg::LSM_STK: begin
                state_q    <= lsm_pkg::LSM_LOAD;
                mem_req_q  <= 1'b1;
                ready_q    <= 1'b0;
                ld_dst_q   <= ra;
                mem_addr_q <= {regs_q[lsm_pkg::SP_IDX][31:2], 2'b00} + stk_off;
              end
              // Target is latched now; the jump waits for the slot instruction
              lsm_pkg::LSM_LINK_RETURN: begin
                state_q  <= lsm_pkg::LSM_SLOT;
                target_q <= regs_q[lsm_pkg::LR_IDX] << 1;
              end
              default: ;
            endcase
          end
        end
        // Ready stays low for the whole load so no second request can overlap
        lsm_pkg::LSM_LOAD: begin
          ready_q <= 1'b0;
          if (i_mem_ack) begin
            state_q   <= lsm_pkg::LSM_IDLE;
            mem_req_q <= 1'b0;
            ready_q   <= 1'b1;
          end
        end
        lsm_pkg::LSM_SLOT: begin
          if (take) begin
            state_q <= lsm_pkg::LSM_IDLE;
            pc_q    <= target_q;
            jump_q  <= 1'b1;
          end
        end
        default: begin
          state_q   <= lsm_pkg::LSM_IDLE;
          mem_req_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_ins_ready   = ready_q;
  assign o_mem_req     = mem_req_q;
  assign o_mem_addr    = mem_addr_q;
  assign o_pc          = pc_q;
  assign o_jump        = jump_q;
  assign o_jump_target = target_q;
  assign o_busy        = mem_req_q;
  assign o_flags       = flags_q;
  assign o_ext         = ext_q;
  assign o_reg_zero    = regs_q[0];
endmodule
`default_nettype wire

// [lsm_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module lsm_chk (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_ins_valid,
  input wire logic [15:0] i_ins,
  input wire logic [3:0]  i_flags,
  input wire logic        i_mem_ack,
  input wire logic        o_ins_ready,
  input wire logic        o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_pc,
  input wire logic        o_jump,
  input wire logic [31:0] o_jump_target,
  input wire logic [3:0]  o_flags,
  input wire logic [10:0] o_ext,
  input wire logic [31:0] o_reg_zero
);
  logic take;
  logic immediate_extender;
  logic slot_q;
  assign take = i_ins_valid && o_ins_ready;
  assign immediate_extender  = (i_ins & lsm_pkg::M_PFX) == lsm_pkg::OP_PFX;
  // High while the delay slot after a taken link return is due
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      slot_q <= 1'b0;
    else if (take)
      slot_q <= (i_ins == lsm_pkg::OP_LINK_RETURN) && !slot_q;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_flags; $past(i_rst_n) |-> o_flags == $past(i_flags); endproperty
  a_flags: assert property (p_flags) else $error("flags altered");
  property p_hold; o_mem_req && !i_mem_ack |=> o_mem_req && !o_ins_ready && $stable(o_mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("load request dropped");
  property p_align; o_mem_req |-> o_mem_addr[1:0] == 2'b00; endproperty
  a_align: assert property (p_align) else $error("load address unaligned");
  property p_pfx; take && immediate_extender |=> o_ext == $past(i_ins[10:0]); endproperty
  a_pfx: assert property (p_pfx) else $error("extension not loaded");
  property p_clr; take && !immediate_extender |=> o_ext == 11'h0; endproperty
  a_clr: assert property (p_clr) else $error("extension not cleared");
  property p_jump; take && slot_q |=> o_jump ##1 !o_jump; endproperty
  a_jump: assert property (p_jump) else $error("jump pulse wrong");
  property p_tgt; o_jump |-> o_pc == o_jump_target && !o_jump_target[0]; endproperty
  a_tgt: assert property (p_tgt) else $error("jump target wrong");
  property p_imm; take && (i_ins & lsm_pkg::M_TOP6) == lsm_pkg::OP_IMM && i_ins[4:0] == 5'h0
    |=> o_reg_zero == {16'h0, $past(o_ext), $past(i_ins[9:5])}; endproperty
  a_imm: assert property (p_imm) else $error("immediate load wrong");
  property p_neg; take && i_ins == lsm_pkg::OP_NEG |=> o_reg_zero == 32'h0 - $past(o_reg_zero); endproperty
  a_neg: assert property (p_neg) else $error("negation wrong");
endmodule
bind lsm_core lsm_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ins_valid(i_ins_valid), .i_ins(i_ins),
  .i_flags(i_flags), .i_mem_ack(i_mem_ack), .o_ins_ready(o_ins_ready), .o_mem_req(o_mem_req),
  .o_mem_addr(o_mem_addr), .o_pc(o_pc), .o_jump(o_jump), .o_jump_target(o_jump_target),
  .o_flags(o_flags), .o_ext(o_ext), .o_reg_zero(o_reg_zero));
`default_nettype wire

// [lsm_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lsm_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [3:0]  i_wait,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      cnt_q   <= 4'h0;
    end else if (i_req && !o_ack && cnt_q == i_wait) begin
      o_ack   <= 1'b1;
      o_rdata <= i_addr ^ 32'h5a5aa5a5;
      cnt_q   <= 4'h0;
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt_q   <= (i_req && !o_ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [cpu_load_shift_move_exec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_load_shift_move_exec_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld = 1'b0;
  logic [15:0] ins = 16'h0;
  logic [3:0]  flg = 4'h0;
  logic [3:0]  wt = 4'h0;
  logic        ack, rdy, req, jmp, busy;
  logic [3:0]  flgo;
  logic [10:0] ext;
  logic [31:0] rdat, adr, pc, tgt, r0, jt;
  logic [31:0] jn = 32'h0;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [47:0] rows [23] = '{{16'h9923,32'h0},{16'h36a0,32'h2475},{16'h6d40,32'h000a2475},{16'h9fff,32'h000a2475},
    {16'h6fe0,32'hffff2475},{16'h2480,32'h0ffff247},{16'h7c20,32'hf0000db9},{16'h1c80,32'h0000db90},
    {16'h7e80,32'h0001b720},{16'h3461,32'h0001b720},{16'h6fe1,32'h0001b720},{16'h2020,32'h000036e4},
    {16'h7ce1,32'h0000a4ac},{16'h7c20,32'hffff5b54},{16'h7e81,32'h001db6ab},{16'h3020,32'h001f0003},
    {16'h3400,32'h0},{16'h3020,32'h001f0003},{16'h9880,32'h001f0003},{16'h346e,32'h001f0003},
    {16'h3611,32'h001f0003},{16'h9802,32'h001f0003},{16'h342f,32'h001f0003}};
  always #2.5 clk = ~clk;
  lsm_core DUT (.i_mclk(clk), .i_rst_n(rst_n), .i_ins_valid(vld), .i_ins(ins), .i_flags(flg), .i_mem_ack(ack),
    .i_mem_rdata(rdat), .o_ins_ready(rdy), .o_mem_req(req), .o_mem_addr(adr), .o_pc(pc), .o_jump(jmp),
    .o_jump_target(tgt), .o_busy(busy), .o_flags(flgo), .o_ext(ext), .o_reg_zero(r0));
  lsm_mem_model MEM (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_addr(adr), .i_wait(wt), .o_ack(ack),
    .o_rdata(rdat));
  always @(negedge clk) begin
    if (jmp === 1'b1) begin
      jn = jn + 32'h1;
      jt = tgt;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1) begin
      if (n == 40) begin
        bad_count++;
        return;
      end
      n++;
      @(negedge clk);
    end
  endtask
  task automatic run(input logic [15:0] w);
    wait_rdy();
    ins = w;
    vld = 1'b1;
    flg = flg + 4'h3;
    @(negedge clk);
    vld = 1'b0;
    @(negedge clk);
    wait_rdy();
    @(negedge clk);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    check({pc[30:0], rdy}, 32'h0);
    rst_n = 1'b1;
    for (int k = 0; k < 23; k++) begin
      run(rows[k][47:32]);
      check(r0, rows[k][31:0]);
      check({28'h0, flgo}, {28'h0, flg});
    end
    check({21'h0, ext}, 32'h0);
    check(pc, 32'h0000002e);
    // Slow answer for the stack load, prompt one for the pointer load
    wt = 4'h5;
    wait_rdy();
    ins = 16'hffe0;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    check(adr, 32'h000013fc);
    check({30'h0, busy, req}, 32'h3);
    wait_rdy();
    @(negedge clk);
    check(r0, 32'h000013fc ^ 32'h5a5aa5a5);
    wt = 4'h0;
    run(16'hb440);
    check(r0, 32'h00000018 ^ 32'h5a5aa5a5);
    wait_rdy();
    ins = 16'h7fcf;
    vld = 1'b1;
    @(negedge clk);
    ins = 16'h34e0;
    @(negedge clk);
    vld = 1'b0;
    repeat (4) @(negedge clk);
    check(jn, 32'h1);
    check(jt, 32'h00000082);
    check(r0, 32'h00000007);
    check(pc, 32'h00000082);
    // A load in the delay slot is dropped, but the jump still happens
    wait_rdy();
    ins = 16'h7fcf;
    vld = 1'b1;
    @(negedge clk);
    ins = 16'hffe0;
    @(negedge clk);
    vld = 1'b0;
    repeat (4) @(negedge clk);
    check(jn, 32'h2);
    check(r0, 32'h00000007);
    check(pc, 32'h00000082);
    test_done();
  end
endmodule
`default_nettype wire
